/* logic/scs_clock_stop_port.sv */
// Purpose: Clock stop (SPI-style) serial port with receive channel select.
// Assumes: Link pins are asynchronous and pass two flip-flops first.
// Notes:   Master makes the link clock by dividing the core clock.
//
// Chosen here: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Two-bit halt field: 0X normal, 10 stop no delay, 11 stop delayed; resets 0.
// - In clock stop mode the clock halts at idle level after each word.
// - Setting 10 gives the first clock edge half a bit after start, setting 11 a full bit after.
// - Transmit polarity picks whether the first edge out of idle rises or falls.
// - Receive polarity picks the sampling edge of the receive clock.
// - In clock stop mode receive clock and frame come from the transmit side.
// - 10, tx pol 0, rx pol 0: idle low, launch rising, sample falling.
// - 11, tx pol 0, rx pol 1: idle low, launch half early, sample rising.
// - 10, tx pol 1, rx pol 0: idle high, launch falling, sample rising.
// - 11, tx pol 1, rx pol 1: idle high, launch half early, sample falling.
// - Channel select off accepts all 128 channels; select bit resets to 0.
// - Channel select on accepts only channels enabled in the enable registers.
// - Partition mode maps channels: 2 partitions or 8 partitions.
// - Receive phase bit: 0 single-phase frame, 1 dual-phase frame.
module scs_clock_stop_port
   import scs_pkg::*;
(
   input  wire logic          ref_clk_in,
   input  wire logic          srst_in,
   input  wire logic [5:0]    address_in,
   input  wire logic          read_in,
   input  wire logic          write_in,
   input  wire logic [31:0]   writedata_in,
   input  wire logic [3:0]    byteenable_in,
   output logic [31:0]        readdata_out,
   output logic               waitrequest_out,
   input  wire scs_link_in_t  link_in,
   output scs_link_out_t      link_out
);
   localparam logic [DIV_W-1:0] DIV_LAST   = DIV_W'(HALF_BIT_CYC - 1);
   localparam logic [4:0]       EDGE_LAST  = 5'(EDGE_COUNT - 1);
   localparam logic [3:0]       WORD_LAST  = 4'(WORD_BITS - 1);
   localparam logic [6:0]       PART2_LAST = 7'(PART2_CHANS - 1);

   typedef struct packed {
      logic [15:0]          spc_one;
      logic [15:0]          mc_one;
      logic [15:0]          rc_two;
      logic [15:0]          link_cfg;
      logic [CHANNELS-1:0]  chan_en;
      logic [WORD_BITS-1:0] tx_data;
      logic                 wait_r;
      logic [31:0]          rdata;
      logic                 pop_pend;
      scs_link_in_t         s1;
      scs_link_in_t         s2;
      logic                 tclk_d;
      logic                 rclk_d;
      logic                 tfs_d;
      logic [DIV_W-1:0]     div;
      scs_state_t           st;
      logic                 busy;
      logic                 clk_lvl;
      logic [4:0]           edges;
      logic [WORD_BITS-1:0] tx_sh;
      logic                 seen;
      logic [WORD_BITS-1:0] rx_sh;
      logic [3:0]           rx_bits;
      logic [6:0]           chan;
      logic                 ovf;
      logic                 push;
      scs_rx_word_t         push_word;
      scs_link_out_t        link;
   } scs_core_t;

   scs_core_t    r;
   scs_core_t    n;
   logic         master, stop, delay, txp, rxp, samp_rise, launch_rise;
   logic         tick, m_edge, m_level, start;
   logic         tx_edge, tx_rise, tx_frame, rx_edge, rx_rise, rx_frame;
   logic         rx_samp, word_done, accept, sel_en, part8, hold, req;
   logic [1:0]   cidx;
   logic         fifo_ready, fifo_valid, fifo_pop;
   scs_rx_word_t fifo_word;
   logic [4:0]   fifo_cnt;

   function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  be);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++)
         if (be[i])
            res[i*8 +: 8] = new_v[i*8 +: 8];
      return res;
   endfunction

   scs_fifo #(
      .WIDTH (RX_WORD_BITS),
      .DEPTH (FIFO_DEPTH)
   ) u_rx_fifo (
      .ref_clk_in    (ref_clk_in),
      .srst_in       (srst_in),
      .in_valid_in   (r.push),
      .in_ready_out  (fifo_ready),
      .in_data_in    (r.push_word),
      .out_valid_out (fifo_valid),
      .out_ready_in  (fifo_pop),
      .out_data_out  (fifo_word),
      .count_out     (fifo_cnt)
   );

   assign fifo_pop        = r.pop_pend && !r.wait_r;
   assign readdata_out    = r.rdata;
   assign waitrequest_out = r.wait_r;
   assign link_out        = r.link;

   always_comb
   begin
      n         = r;
      n.s1      = link_in;
      n.s2      = r.s1;
      n.tclk_d  = r.s2.tx_clk;
      n.rclk_d  = r.s2.rx_clk;
      n.tfs_d   = r.s2.tx_fs_n;
      n.push    = 1'b0;
      master    = r.link_cfg[CFG_MASTER_BIT];
      txp       = r.link_cfg[CFG_TXPOL_BIT];
      rxp       = r.link_cfg[CFG_RXPOL_BIT];
      stop      = r.spc_one[HALT_ON_BIT];
      delay     = r.spc_one[HALT_DELAY_BIT];
      sel_en    = r.mc_one[SEL_EN_BIT];
      part8     = r.mc_one[PART_MODE_BIT];
      // Sample edge: stop mode ties both polarities together
      samp_rise   = stop ? (txp ^ rxp) : rxp;
      launch_rise = stop ? !samp_rise : !txp;
      // ----------------------------------------------------------------
      // Bit-rate divider and master clock generator
      // ----------------------------------------------------------------
      tick   = (r.div == DIV_LAST);
      n.div  = tick ? '0 : r.div + 1'b1;
      m_edge = 1'b0;
      case (r.st)
         ST_IDLE:
            m_edge = master && !stop && tick;
         ST_LEAD:
            if (tick)
               n.st = ST_SHIFT;
         ST_SHIFT:
            if (tick)
            begin
               m_edge  = 1'b1;
               n.edges = r.edges + 1'b1;
               if (r.edges == EDGE_LAST)
               begin
                  n.st   = ST_IDLE;
                  n.busy = 1'b0;
               end
            end
         default:
            n.st = ST_IDLE;
      endcase
      m_level   = r.clk_lvl ^ m_edge;
      n.clk_lvl = m_level;
      if (n.st == ST_IDLE && (stop || !master))
         n.clk_lvl = txp;
      // ----------------------------------------------------------------
      // Bus slave: one wait cycle, more for master transmit writes while busy or receive buffer full, then the answer
      // ----------------------------------------------------------------
      req   = read_in || write_in;
      hold  = write_in && address_in == ADDR_TX_DATA && master
              && (r.busy || !fifo_ready);
      start = 1'b0;
      cidx  = address_in[3:2];
      if (r.wait_r)
      begin
         if (req && !hold)
         begin
            n.wait_r   = 1'b0;
            n.pop_pend = read_in && address_in == ADDR_RX_DATA && fifo_valid;
            n.rdata    = 32'h0000_0000;
            case (address_in)
               ADDR_SPC_ONE:  n.rdata = {16'h0000, r.spc_one};
               ADDR_MC_ONE:   n.rdata = {16'h0000, r.mc_one};
               ADDR_RC_TWO:   n.rdata = {16'h0000, r.rc_two};
               ADDR_LINK_CFG: n.rdata = {16'h0000, r.link_cfg};
               ADDR_TX_DATA:  n.rdata = {24'h00_0000, r.tx_data};
               // Empty buffer reads zero, not a stale entry
               ADDR_RX_DATA:  n.rdata = fifo_valid
                                 ? {1'b1, 8'h00, fifo_word.channel, 7'h00,
                                    fifo_word.phase, fifo_word.data}
                                 : 32'h0000_0000;
               ADDR_STATUS:   n.rdata = {9'h000, r.chan, 2'h0, rx_frame_q(),
                                         fifo_cnt, 6'h00, r.ovf, r.busy};
               default:
                  if (address_in[5:4] == ADDR_CHAN_HI)
                     n.rdata = r.chan_en[{cidx, 5'h00} +: 32];
            endcase
         end
      end
      else
      begin
         n.wait_r   = 1'b1;
         n.pop_pend = 1'b0;
         if (write_in)
         begin
            case (address_in)
               ADDR_SPC_ONE:
                  n.spc_one = 16'(be_merge({16'h0000, r.spc_one},
                                           writedata_in, byteenable_in));
               ADDR_MC_ONE:
                  n.mc_one = 16'(be_merge({16'h0000, r.mc_one},
                                          writedata_in, byteenable_in));
               ADDR_RC_TWO:
                  n.rc_two = 16'(be_merge({16'h0000, r.rc_two},
                                          writedata_in, byteenable_in));
               ADDR_LINK_CFG:
                  n.link_cfg = 16'(be_merge({16'h0000, r.link_cfg},
                                            writedata_in, byteenable_in));
               ADDR_TX_DATA:
                  if (byteenable_in[0])
                  begin
                     n.tx_data = writedata_in[WORD_BITS-1:0];
                     start     = master && !r.busy;
                  end
               ADDR_STATUS:
                  if (byteenable_in[0] && writedata_in[STAT_OVF_BIT])
                     n.ovf = 1'b0;
               default:
                  if (address_in[5:4] == ADDR_CHAN_HI)
                     n.chan_en[{cidx, 5'h00} +: 32] = be_merge(
                        r.chan_en[{cidx, 5'h00} +: 32], writedata_in,
                        byteenable_in);
            endcase
         end
      end
      // Restart the divider so the first half bit is full length
      if (start)
      begin
         n.busy  = 1'b1;
         n.st    = (stop && delay) ? ST_LEAD : ST_SHIFT;
         n.div   = '0;
         n.edges = '0;
         n.tx_sh = writedata_in[WORD_BITS-1:0];
         n.seen  = 1'b0;
      end
      // ----------------------------------------------------------------
      // Edge sources for both directions
      // ----------------------------------------------------------------
      tx_edge  = master ? m_edge : (r.s2.tx_clk != r.tclk_d);
      tx_rise  = master ? m_level : r.s2.tx_clk;
      tx_frame = master ? r.busy : !r.s2.tx_fs_n;
      rx_edge  = stop ? tx_edge : (r.s2.rx_clk != r.rclk_d);
      rx_rise  = stop ? tx_rise : r.s2.rx_clk;
      rx_frame = stop ? tx_frame : !r.s2.rx_fs_n;
      if (!master && !r.s2.tx_fs_n && r.tfs_d)
      begin
         n.tx_sh = r.tx_data;
         n.seen  = 1'b0;
      end
      // Launch edges before the first sample edge keep bit 7; later ones shift the next bit out
      else if (tx_frame && tx_edge)
      begin
         if (tx_rise == launch_rise)
         begin
            if (r.seen)
               n.tx_sh = {r.tx_sh[WORD_BITS-2:0], 1'b0};
         end
         else
            n.seen = 1'b1;
      end
      // ----------------------------------------------------------------
      // Receive shifter and channel selection
      // ----------------------------------------------------------------
      rx_samp   = rx_frame && rx_edge && (rx_rise == samp_rise);
      word_done = rx_samp && r.rx_bits == WORD_LAST;
      accept    = !sel_en
                  || (r.chan_en[r.chan]
                      && (part8 || r.chan <= PART2_LAST));
      if (!rx_frame)
      begin
         n.rx_bits = '0;
         n.chan    = '0;
      end
      else if (rx_samp)
      begin
         n.rx_sh   = {r.rx_sh[WORD_BITS-2:0], r.s2.dr};
         n.rx_bits = word_done ? '0 : r.rx_bits + 1'b1;
         if (word_done)
         begin
            n.chan = r.chan + 1'b1;
            if (accept && fifo_ready)
            begin
               n.push                 = 1'b1;
               n.push_word.channel    = r.chan;
               n.push_word.data       = n.rx_sh;
               n.push_word.phase      = r.rc_two[PHASE_BIT]
                  && r.chan > r.link_cfg[CFG_PH1_LSB +: 7];
            end
            else if (accept)
               n.ovf = 1'b1;
         end
      end
      // ----------------------------------------------------------------
      // Pin drivers, registered
      // ----------------------------------------------------------------
      n.link.clk      = n.clk_lvl;
      n.link.clk_oe_n = !master;
      n.link.fs_n     = !n.busy;
      n.link.fs_oe_n  = !master;
      n.link.dx       = n.tx_sh[WORD_BITS-1];
      n.link.dx_oe_n  = master ? !n.busy : r.s2.tx_fs_n;
      if (srst_in)
      begin
         n          = '0;
         n.spc_one  = SPC_ONE_RST;
         n.mc_one   = MC_ONE_RST;
         n.rc_two   = RC_TWO_RST;
         n.link_cfg = LINK_CFG_RST;
         n.wait_r   = 1'b1;
         n.st       = ST_IDLE;
         n.s1       = '1;
         n.s2       = '1;
         n.tfs_d    = 1'b1;
         n.link     = '{clk: 1'b0, clk_oe_n: 1'b1, fs_n: 1'b1,
                        fs_oe_n: 1'b1, dx: 1'b0, dx_oe_n: 1'b1};
      end
   end

   function automatic logic rx_frame_q();
      return r.spc_one[HALT_ON_BIT]
             ? (r.link_cfg[CFG_MASTER_BIT] ? r.busy : !r.s2.tx_fs_n)
             : !r.s2.rx_fs_n;
   endfunction

   always_ff @(posedge ref_clk_in)
   begin
      r <= n;
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (srst_in);

   sequence seq_stop_start;
      start && stop && master;
   endsequence

   halt_reset_val_a: assert property (
      $past(srst_in) |-> r.spc_one[12:11] == 2'b00 && !r.mc_one[SEL_EN_BIT])
      else $error("halt or select field not cleared by reset");
   clock_halts_a: assert property (
      stop && master && r.st == ST_SHIFT && tick && r.edges == EDGE_LAST
      |=> r.st == ST_IDLE && r.link.clk == $past(txp) && r.link.fs_n)
      else $error("clock not parked at idle level after word");
   start_no_delay_a: assert property (
      seq_stop_start ##0 !delay
      |=> $stable(r.link.clk) [*4] ##1 $changed(r.link.clk))
      else $error("undelayed clock start mistimed");
   start_delay_a: assert property (
      seq_stop_start ##0 delay
      |=> $stable(r.link.clk) [*8] ##1 $changed(r.link.clk))
      else $error("delayed clock start mistimed");
   first_edge_a: assert property (
      stop && master && r.st == ST_SHIFT && r.edges == 5'd1
      |-> r.link.clk != txp)
      else $error("first clock edge in wrong direction");
   sample_edge_a: assert property (
      stop && master && rx_samp |=> r.link.clk == $past(samp_rise))
      else $error("receive sampled on wrong clock edge");
   launch_edge_a: assert property (
      stop && master && r.st == ST_SHIFT && r.edges != 5'd0
      && $changed(r.tx_sh) |-> $changed(r.link.clk) && r.link.clk != samp_rise)
      else $error("transmit bit launched on wrong edge");
   rx_tied_a: assert property (
      stop |-> rx_frame == (master ? r.busy : !r.s2.tx_fs_n)
      && rx_edge == tx_edge)
      else $error("receive frame not tied to transmit frame");
   accept_all_a: assert property (
      word_done && !sel_en && fifo_ready |=> r.push)
      else $error("word dropped with channel select off");
   select_only_a: assert property (
      word_done && sel_en && !r.chan_en[r.chan] |=> !r.push)
      else $error("disabled channel accepted");
   partition_a: assert property (
      word_done && sel_en && !part8 && r.chan > PART2_LAST |=> !r.push)
      else $error("channel beyond two partitions accepted");
   phase_single_a: assert property (
      r.push && !r.rc_two[PHASE_BIT] |-> !r.push_word.phase)
      else $error("second phase seen in single-phase frame");
   frame_select_a: assert property (
      seq_stop_start |=> !r.link.fs_n && !r.link.dx_oe_n)
      else $error("slave select not asserted at transfer start");
endmodule
`default_nettype wire

/* logic/scs_fifo.sv */
// Purpose: Receive word buffer with valid/ready on both sides.
// Assumes: DEPTH is a power of two.
// Notes:   in_ready_out is the honest "not full" of the store.
`timescale 1ns/1ps
`default_nettype none
module scs_fifo
   import scs_pkg::*;
#(
   parameter int WIDTH = RX_WORD_BITS,
   parameter int DEPTH = FIFO_DEPTH
)(
   input  wire logic                  ref_clk_in,
   input  wire logic                  srst_in,
   input  wire logic                  in_valid_in,
   output logic                       in_ready_out,
   input  wire logic [WIDTH-1:0]      in_data_in,
   output logic                       out_valid_out,
   input  wire logic                  out_ready_in,
   output logic [WIDTH-1:0]           out_data_out,
   output logic [$clog2(DEPTH):0]     count_out
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wr;
      logic [AW-1:0]               rd;
      logic [AW:0]                 cnt;
   } scs_fifo_state_t;
   scs_fifo_state_t f_reg;
   scs_fifo_state_t f_next;
   logic            push;
   logic            pop;

   assign in_ready_out  = f_reg.cnt < (AW+1)'(DEPTH);
   assign out_valid_out = f_reg.cnt != '0;
   assign out_data_out  = f_reg.mem[f_reg.rd];
   assign count_out     = f_reg.cnt;

   always_comb
   begin
      push   = in_valid_in && in_ready_out;
      pop    = out_ready_in && out_valid_out;
      f_next = f_reg;
      if (push)
      begin
         f_next.mem[f_reg.wr] = in_data_in;
         f_next.wr            = f_reg.wr + 1'b1;
      end
      if (pop)
         f_next.rd = f_reg.rd + 1'b1;
      f_next.cnt = f_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge ref_clk_in)
   begin
      if (srst_in)
         f_reg <= '0;
      else
         f_reg <= f_next;
   end
endmodule
`default_nettype wire

/* logic/scs_pkg.sv */
// Purpose: Shared constants and types for the clock stop serial port.
// Assumes: 50 MHz core clock, 160 ns link bit period, 8-bit words.
// Notes:   Register addresses are byte addresses on a 32-bit bus.
`default_nettype none
package scs_pkg;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 20;
   localparam int HALF_BIT_NS   = 80;
   localparam int HALF_BIT_CYC  = (HALF_BIT_NS + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;
   localparam int DIV_W         = $clog2(HALF_BIT_CYC);
   localparam int WORD_BITS     = 8;
   localparam int EDGE_COUNT    = 2 * WORD_BITS;
   localparam int FIFO_DEPTH    = 16;
   localparam int CHANNELS      = 128;
   localparam int PART2_CHANS   = 32;
   // ----------------------------------------------------------------
   // Register byte addresses
   // ----------------------------------------------------------------
   localparam logic [5:0] ADDR_SPC_ONE  = 6'h00;
   localparam logic [5:0] ADDR_MC_ONE   = 6'h04;
   localparam logic [5:0] ADDR_RC_TWO   = 6'h08;
   localparam logic [5:0] ADDR_LINK_CFG = 6'h0C;
   localparam logic [5:0] ADDR_TX_DATA  = 6'h10;
   localparam logic [5:0] ADDR_RX_DATA  = 6'h14;
   localparam logic [5:0] ADDR_STATUS   = 6'h18;
   localparam logic [1:0] ADDR_CHAN_HI  = 2'h2;   // 0x20..0x2C
   // ----------------------------------------------------------------
   // Field positions and reset values
   // ----------------------------------------------------------------
   localparam int HALT_ON_BIT    = 12;
   localparam int HALT_DELAY_BIT = 11;
   localparam int SEL_EN_BIT     = 0;
   localparam int PART_MODE_BIT  = 9;
   localparam int PHASE_BIT      = 15;
   localparam int CFG_MASTER_BIT = 0;
   localparam int CFG_TXPOL_BIT  = 1;
   localparam int CFG_RXPOL_BIT  = 2;
   localparam int CFG_PH1_LSB    = 8;
   localparam int STAT_OVF_BIT   = 1;
   localparam logic [15:0] SPC_ONE_RST  = 16'h0000;
   localparam logic [15:0] MC_ONE_RST   = 16'h0000;
   localparam logic [15:0] RC_TWO_RST   = 16'h0000;
   localparam logic [15:0] LINK_CFG_RST = 16'h0000;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_LEAD  = 2'b01,
      ST_SHIFT = 2'b10
   } scs_state_t;

   typedef struct packed {
      logic [6:0]           channel;
      logic                 phase;
      logic [WORD_BITS-1:0] data;
   } scs_rx_word_t;
   localparam int RX_WORD_BITS = $bits(scs_rx_word_t);

   typedef struct packed {
      logic tx_clk;
      logic tx_fs_n;
      logic rx_clk;
      logic rx_fs_n;
      logic dr;
   } scs_link_in_t;

   typedef struct packed {
      logic clk;
      logic clk_oe_n;
      logic fs_n;
      logic fs_oe_n;
      logic dx;
      logic dx_oe_n;
   } scs_link_out_t;
endpackage
`default_nettype wire

/* tb/scs_spi_peer.sv */
// Purpose: Behavioural slave peer on the clock stop link.
// Assumes: The bench sets the sample edge from the polarity bits.
// Notes:   No pull on the data line, so release shows the inverse bit.
`timescale 1ns/1ps
`default_nettype none
module scs_spi_peer (
   input  wire logic       sclk_in,
   input  wire logic       sel_n_in,
   input  wire logic       mosi_in,
   input  wire logic       sample_rise_in,
   input  wire logic [7:0] tx_byte_in,
   output logic            miso_out,
   output logic [7:0]      rx_byte_out
);
   int n = 8;
   initial miso_out = 1'b0;
   initial rx_byte_out = 8'h00;
   // First bit is ready before any edge, as the delayed scheme needs
   always @(negedge sel_n_in)
   begin
      n = 0;
      miso_out = tx_byte_in[7];
   end
   always @(posedge sel_n_in) miso_out = ~miso_out;
   // Last sample may meet the select release, so count bits, not select
   always @(sclk_in)
      if (sclk_in === sample_rise_in && n < 8)
      begin
         rx_byte_out = {rx_byte_out[6:0], mosi_in};
         n = n + 1;
      end
      else if (n > 0 && n < 8)
         miso_out = tx_byte_in[7 - n];
endmodule
`default_nettype wire

/* tb/tb.sv */
// Purpose: Self-checking bench for the clock stop serial port.
// Assumes: Device is link master, the peer a behavioural slave.
// Notes:   A queue predicts the receive buffer contents.
`timescale 1ns/1ps
`default_nettype none
module tb
   import scs_pkg::*;
;
   logic          ref_clk_in = 1'b0;
   logic          srst_in = 1'b1;
   logic          rd = 1'b0, wr = 1'b0, rise = 1'b0, miso, wq;
   logic [1:0]    rnd = 2'b00;
   logic [5:0]    adr = 6'h00;
   logic [7:0]    pb, txb, rxb;
   logic [31:0]   wd = 32'h0, rdv, rdata, q[$];
   scs_link_out_t lout;
   int            fails = 0, total_checks = 0, cyc = 0, i;
   int            seed = 32'h1195;
   initial forever #(CLK_PERIOD_NS / 2) ref_clk_in = ~ref_clk_in;
   // Receive pins toggle at random; stop mode must ignore them
   scs_clock_stop_port i_scs_clock_stop_port (.ref_clk_in, .srst_in,
      .address_in(adr), .read_in(rd), .write_in(wr), .writedata_in(wd),
      .byteenable_in(4'hF), .readdata_out(rdata), .waitrequest_out(wq),
      .link_in({1'b0, 1'b1, rnd, miso}), .link_out(lout));
   scs_spi_peer i_scs_spi_peer (.sclk_in(lout.clk), .sel_n_in(lout.fs_n),
      .mosi_in(lout.dx), .sample_rise_in(rise), .tx_byte_in(pb),
      .miso_out(miso), .rx_byte_out(rxb));
   task tally_and_finish;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   always @(posedge ref_clk_in)
   begin
      rnd <= 2'($random(seed));
      cyc <= cyc + 1;
      if (cyc == 9000)
      begin
         fails = fails + 1;
         tally_and_finish;
      end
   end
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task step(inout int k);
      @(posedge ref_clk_in);
      k++;
   endtask
   task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge ref_clk_in);
      rd <= !w;
      wr <= w;
      adr <= a;
      wd <= d;
      do step(k); while (wq !== 1'b0 && k < 2000);
      rdv = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   task rdchk(input logic [5:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(rdv, e);
   endtask
   // Mode m: bit 0 transmit polarity, bit 1 both delay and rx polarity
   task automatic word(input logic [1:0] m);
      int k;
      bus(1'b1, ADDR_LINK_CFG, {29'h0, m[1], m[0], 1'b1});
      bus(1'b1, ADDR_SPC_ONE, {19'h0, 1'b1, m[1], 11'h0});
      rise = ^m;
      pb = 8'($random(seed));
      txb = 8'($random(seed));
      bus(1'b1, ADDR_TX_DATA, {24'h0, txb});
      k = 0;
      while (lout.fs_n !== 1'b0 && k < 50) step(k);
      k = 0;
      while (lout.clk === m[0] && k < 50) step(k);
      chk(k, HALF_BIT_CYC * (1 + m[1]));
      chk({lout.clk_oe_n, lout.fs_oe_n, lout.dx_oe_n}, 3'b000);
      k = 0;
      while (lout.fs_n === 1'b0 && k < 300) step(k);
      chk(k, (EDGE_COUNT - 1) * HALF_BIT_CYC);
      chk({lout.clk, lout.dx_oe_n}, {m[0], 1'b1});
      chk(rxb, txb);
   endtask
   initial
   begin
      repeat (10) @(posedge ref_clk_in);
      srst_in <= 1'b0;
      for (i = 0; i < 5; i++)
         rdchk((i == 4) ? 6'h3C : 6'(4 * i), 32'h0);
      bus(1'b1, ADDR_RC_TWO, 32'h8000);
      rdchk(ADDR_RC_TWO, 32'h8000);
      for (i = 0; i < FIFO_DEPTH; i++)
      begin
         word(2'(i));
         q.push_back({24'h80_0000, pb});
      end
      repeat (10) @(posedge ref_clk_in);
      rdchk(ADDR_STATUS, 32'h1000);
      while (q.size() > 0)
         rdchk(ADDR_RX_DATA, q.pop_front());
      rdchk(ADDR_RX_DATA, 32'h0);
      bus(1'b1, ADDR_MC_ONE, 32'h1);
      word(2'd0);
      rdchk(ADDR_RX_DATA, 32'h0);
      bus(1'b1, ADDR_MC_ONE, 32'h201);
      bus(1'b1, 6'h20, 32'h1);
      word(2'd3);
      rdchk(ADDR_RX_DATA, {24'h80_0000, pb});
      tally_and_finish;
   end
endmodule
`default_nettype wire
